// ---- src/gts_defines.vh ----
// Constants for the gate and task switch control block
// Functional notes
// - Gate usable only when effective privilege is at least the gate's privilege.
// - Gate transfer only to same or more privileged code level.
// - 32-bit inter-level call: load target, push stack selector, pointer, params, return.
// - 16-bit call gate: same sequence with 16-bit pushes and parameters.
// - Interrupt/trap gates copy no parameters; interrupt gate clears IF.
// - Task switch starts on jump/call to task segment or gate, or gated interrupt.
// - Task switch saves state, links old task, loads new, checks, runs.
// - 32-bit task segment limit above 0064H, 16-bit above 002BH.
// - Loading task selector register also loads hidden base and limit.
// - Interrupt return switches back to previous task when nested flag set.
// - Call/interrupt switch marks busy, writes back link, sets nested flag.
// - Interrupt without switch clears nested flag; restored after handler for interrupt gates only.
// - Busy marking changes type 9H to BH, or 1 to 3.
// - Selecting a busy task segment raises exception 13.
// - Virtual-8086 flag bit 17 set only through task switch; real addressing.
// - Every task switch sets task-switched bit 3 of control word 0.
// - Task-switched and monitor bits set: numeric or wait raises exception 7.
// - Debug-trap bit in incoming task raises debug exception 1.
// - Reset starts real mode; protection-enable bit set enters protected mode.
`ifndef GTS_DEFINES_VH
`define GTS_DEFINES_VH
`define GTS_ADDR_CTRL     8'h00
`define GTS_ADDR_CMD      8'h04
`define GTS_ADDR_DESC     8'h08
`define GTS_ADDR_LIMIT    8'h0C
`define GTS_ADDR_SEL      8'h10
`define GTS_ADDR_FLAGS    8'h14
`define GTS_ADDR_STATUS   8'h18
`define GTS_ADDR_TRSEL    8'h1C
`define GTS_ADDR_TRBASE   8'h20
`define GTS_ADDR_TRLIM    8'h24
`define GTS_ADDR_PUSH     8'h28
`define GTS_ADDR_NPUSH    8'h2C
`define GTS_ADDR_BASE     8'h30
`define GTS_CR0_PE        0
`define GTS_CR0_MP        1
`define GTS_CR0_TS        3
`define GTS_FL_IF         9
`define GTS_FL_NT         14
`define GTS_FL_VM         17
`define GTS_OP_CALL       3'h1
`define GTS_OP_JMP        3'h2
`define GTS_OP_INT        3'h3
`define GTS_OP_INTERRUPT_RETURN       3'h4
`define GTS_OP_FPU        3'h5
`define GTS_DT_TSS16      4'h1
`define GTS_DT_TSS16_BUSY 4'h3
`define GTS_DT_CALL16     4'h4
`define GTS_DT_TGATE      4'h5
`define GTS_DT_INT16      4'h6
`define GTS_DT_TRAP16     4'h7
`define GTS_DT_TSS32      4'h9
`define GTS_DT_TSS32_BUSY 4'hB
`define GTS_DT_CALL32     4'hC
`define GTS_DT_INT32      4'hE
`define GTS_DT_TRAP32     4'hF
`define GTS_MIN_LIM32     32'h00000064
`define GTS_MIN_LIM16     32'h0000002B
`define GTS_EXC_NONE      8'h00
`define GTS_EXC_DEBUG     8'h01
`define GTS_EXC_NOFPU     8'h07
`define GTS_EXC_GP        8'h0D
`define GTS_SWITCH_NS     10000
`define GTS_CLK_NS        100
`define GTS_SWITCH_CYC    ((`GTS_SWITCH_NS) / (`GTS_CLK_NS))
`define GTS_RESP_OKAY     2'h0
`define GTS_RESP_SLVERR   2'h2
`endif

// ---- src/gts_priv_check.v ----
// Privilege and descriptor type checker for one transfer request
`timescale 1ns/10ps
`include "gts_defines.vh"
module gts_priv_check (
	input  wire [2:0]  op,
	input  wire [3:0]  dtype,
	input  wire [1:0]  cpl,
	input  wire [1:0]  rpl,
	input  wire [1:0]  descriptor_privilege,
	input  wire [1:0]  target_dpl,
	input  wire [31:0] limit,
	output reg         is_gate,
	output reg         is_task,
	output reg         is_tss,
	output reg         wide,
	output reg         fault
);
	reg [1:0] effective_privilege;
	always @* begin
		effective_privilege = (rpl > cpl) ? rpl : cpl;
		is_gate = (dtype == `GTS_DT_CALL32) || (dtype == `GTS_DT_CALL16) ||
			(dtype == `GTS_DT_INT32) || (dtype == `GTS_DT_INT16) ||
			(dtype == `GTS_DT_TRAP32) || (dtype == `GTS_DT_TRAP16);
		is_tss = (dtype == `GTS_DT_TSS32) || (dtype == `GTS_DT_TSS16) ||
			(dtype == `GTS_DT_TSS32_BUSY) || (dtype == `GTS_DT_TSS16_BUSY);
		is_task = is_tss || (dtype == `GTS_DT_TGATE);
		wide = dtype[3];
		fault = 1'b0;
		if (effective_privilege > descriptor_privilege)
			fault = 1'b1;
		if (is_gate && (target_dpl > cpl))
			fault = 1'b1;
		if (!is_gate && !is_task)
			fault = 1'b1;
		if (op == `GTS_OP_JMP && is_gate)
			fault = 1'b1;
		if ((dtype == `GTS_DT_TSS32_BUSY) || (dtype == `GTS_DT_TSS16_BUSY))
			fault = 1'b1;
		if (is_tss && dtype[3] && (limit <= `GTS_MIN_LIM32))
			fault = 1'b1;
		if (is_tss && !dtype[3] && (limit <= `GTS_MIN_LIM16))
			fault = 1'b1;
	end
endmodule // gts_priv_check

// ---- src/gts_ctrl_word.v ----
// Small resettable control word register with write strobe
`timescale 1ns/10ps
module gts_ctrl_word #(
	parameter [31:0] RESET_VAL = 32'h00000000
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire        wr_en,
	input  wire [31:0] wr_data,
	input  wire [3:0]  wstrb,
	output reg  [31:0] q_reg
);
	integer i;
	always @(posedge aclk) begin
		if (!aresetn) begin
			q_reg <= RESET_VAL;
		end else if (wr_en) begin
			for (i = 0; i < 4; i = i + 1) begin
				if (wstrb[i])
					q_reg[i*8 +: 8] <= wr_data[i*8 +: 8];
			end
		end
	end
endmodule // gts_ctrl_word

// ---- src/gts_task_ctrl.v ----
// Gate entry and task switch controller with AXI4-Lite register access
`timescale 1ns/10ps
`include "gts_defines.vh"
module gts_task_ctrl (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg         busy_reg
);
	localparam [3:0] ST_IDLE = 4'b0001;
	localparam [3:0] ST_PUSH = 4'b0010;
	localparam [3:0] ST_TASK = 4'b0100;
	localparam [3:0] ST_DONE = 4'b1000;
	localparam [15:0] SWITCH_CYC = `GTS_SWITCH_CYC;

	reg  [3:0]  state_reg;
	reg  [7:0]  aw_addr_reg;
	reg         aw_have_reg;
	reg  [31:0] w_data_reg;
	reg  [3:0]  w_strb_reg;
	reg         w_have_reg;
	reg  [31:0] flags_reg;
	reg  [31:0] saved_flags_reg;
	reg         saved_nt_valid_reg;
	reg  [15:0] task_segment_selector_reg;
	reg  [31:0] tr_base_reg;
	reg  [31:0] tr_limit_reg;
	reg  [15:0] back_link_reg;
	reg  [7:0]  exc_reg;
	reg         done_reg;
	reg  [3:0]  busy_type_reg;
	reg  [15:0] cnt_reg;
	reg  [4:0]  npush_reg;
	reg  [31:0] last_push_reg;
	reg  [2:0]  op_reg;
	reg         wide_reg;
	reg         dbg_pending_reg;
	reg         cmd_start;
	reg         ts_reg;

	wire [31:0] machine_control_word_0;
	wire [31:0] desc_q;
	wire [31:0] limit_q;
	wire [31:0] sel_q;
	wire [31:0] base_q;
	wire        wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid;
	wire        wr_ctrl = wr_go && (aw_addr_reg == `GTS_ADDR_CTRL);
	wire        wr_desc = wr_go && (aw_addr_reg == `GTS_ADDR_DESC);
	wire        wr_lim = wr_go && (aw_addr_reg == `GTS_ADDR_LIMIT);
	wire        wr_sel = wr_go && (aw_addr_reg == `GTS_ADDR_SEL);
	wire        wr_base = wr_go && (aw_addr_reg == `GTS_ADDR_BASE);
	wire        wr_flags = wr_go && (aw_addr_reg == `GTS_ADDR_FLAGS);
	wire        wr_cmd = wr_go && (aw_addr_reg == `GTS_ADDR_CMD);
	wire        addr_ok = (aw_addr_reg <= `GTS_ADDR_BASE) && (aw_addr_reg[1:0] == 2'b00);
	wire        is_gate;
	wire        is_task;
	wire        is_tss;
	wire        wide;
	wire        chk_fault;
	wire [2:0]  cmd_op = w_data_reg[2:0];
	wire        prot_mode = machine_control_word_0[`GTS_CR0_PE];

	assign s_axi_awready = !aw_have_reg;
	assign s_axi_wready = !w_have_reg;
	assign s_axi_arready = !s_axi_rvalid;

	// Software-owned control words
	gts_ctrl_word u_cr0 (
		.aclk    (aclk),
		.aresetn (aresetn),
		.wr_en   (wr_ctrl),
		.wr_data ({w_data_reg[31:4], machine_control_word_0[3], w_data_reg[2:0]}),
		.wstrb   (w_strb_reg),
		.q_reg   (machine_control_word_0)
	);
	gts_ctrl_word u_desc (
		.aclk    (aclk),
		.aresetn (aresetn),
		.wr_en   (wr_desc),
		.wr_data (w_data_reg),
		.wstrb   (w_strb_reg),
		.q_reg   (desc_q)
	);
	gts_ctrl_word u_lim (
		.aclk    (aclk),
		.aresetn (aresetn),
		.wr_en   (wr_lim),
		.wr_data (w_data_reg),
		.wstrb   (w_strb_reg),
		.q_reg   (limit_q)
	);
	gts_ctrl_word u_sel (
		.aclk    (aclk),
		.aresetn (aresetn),
		.wr_en   (wr_sel),
		.wr_data (w_data_reg),
		.wstrb   (w_strb_reg),
		.q_reg   (sel_q)
	);
	gts_ctrl_word u_base (
		.aclk    (aclk),
		.aresetn (aresetn),
		.wr_en   (wr_base),
		.wr_data (w_data_reg),
		.wstrb   (w_strb_reg),
		.q_reg   (base_q)
	);

	// Descriptor word: [3:0] type, [5:4] privilege, [7:6] target privilege,
	// [12:8] parameter count, [13] debug trap, [14] incoming virtual flag
	gts_priv_check u_chk (
		.op         (cmd_op),
		.dtype      (desc_q[3:0]),
		.cpl        (sel_q[31:30]),
		.rpl        (sel_q[1:0]),
		.descriptor_privilege        (desc_q[5:4]),
		.target_dpl (desc_q[7:6]),
		.limit      (limit_q),
		.is_gate    (is_gate),
		.is_task    (is_task),
		.is_tss     (is_tss),
		.wide       (wide),
		.fault      (chk_fault)
	);

	// Write channel capture, either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `GTS_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_have_reg) begin
				aw_have_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_have_reg) begin
				w_have_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= addr_ok ? `GTS_RESP_OKAY : `GTS_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `GTS_RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `GTS_RESP_OKAY;
			case (s_axi_araddr)
				`GTS_ADDR_CTRL:   s_axi_rdata <= {machine_control_word_0[31:4], ts_reg,
					machine_control_word_0[2:0]};
				`GTS_ADDR_CMD:    s_axi_rdata <= {29'h0, op_reg};
				`GTS_ADDR_DESC:   s_axi_rdata <= desc_q;
				`GTS_ADDR_LIMIT:  s_axi_rdata <= limit_q;
				`GTS_ADDR_SEL:    s_axi_rdata <= sel_q;
				`GTS_ADDR_FLAGS:  s_axi_rdata <= flags_reg;
				`GTS_ADDR_STATUS: s_axi_rdata <= {busy_type_reg, back_link_reg, exc_reg,
					done_reg, busy_reg, prot_mode, 1'b0};
				`GTS_ADDR_TRSEL:  s_axi_rdata <= {16'h0000, task_segment_selector_reg};
				`GTS_ADDR_TRBASE: s_axi_rdata <= tr_base_reg;
				`GTS_ADDR_TRLIM:  s_axi_rdata <= tr_limit_reg;
				`GTS_ADDR_PUSH:   s_axi_rdata <= last_push_reg;
				`GTS_ADDR_NPUSH:  s_axi_rdata <= {27'h0, npush_reg};
				`GTS_ADDR_BASE:   s_axi_rdata <= base_q;
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `GTS_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	always @* begin
		cmd_start = wr_cmd && !busy_reg;
	end

	// Transfer engine
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= ST_IDLE;
			busy_reg <= 1'b0;
			flags_reg <= 32'h00000002;
			saved_flags_reg <= 32'h00000000;
			saved_nt_valid_reg <= 1'b0;
			task_segment_selector_reg <= 16'h0000;
			tr_base_reg <= 32'h00000000;
			tr_limit_reg <= 32'h00000000;
			back_link_reg <= 16'h0000;
			exc_reg <= `GTS_EXC_NONE;
			done_reg <= 1'b0;
			busy_type_reg <= 4'h0;
			cnt_reg <= 16'h0000;
			npush_reg <= 5'h00;
			last_push_reg <= 32'h00000000;
			op_reg <= 3'h0;
			wide_reg <= 1'b0;
		end else begin
			if (wr_flags && !busy_reg)
				flags_reg <= {14'h0, flags_reg[`GTS_FL_VM], w_data_reg[16:0]};
			case (state_reg)
				ST_IDLE: begin
					if (cmd_start) begin
						op_reg <= cmd_op;
						done_reg <= 1'b0;
						exc_reg <= `GTS_EXC_NONE;
						if (cmd_op == `GTS_OP_FPU) begin
							if (ts_reg &&
								machine_control_word_0[`GTS_CR0_MP])
								exc_reg <= `GTS_EXC_NOFPU;
							done_reg <= 1'b1;
						end else if (!prot_mode) begin
							done_reg <= 1'b1;
						end else if (cmd_op == `GTS_OP_INTERRUPT_RETURN) begin
							if (flags_reg[`GTS_FL_NT]) begin
								// Return to the linked task
								busy_reg <= 1'b1;
								cnt_reg <= SWITCH_CYC;
								state_reg <= ST_TASK;
							end else begin
								if (saved_nt_valid_reg)
									flags_reg[`GTS_FL_NT] <= saved_flags_reg[`GTS_FL_NT];
								saved_nt_valid_reg <= 1'b0;
								done_reg <= 1'b1;
							end
						end else if (chk_fault) begin
							exc_reg <= `GTS_EXC_GP;
							done_reg <= 1'b1;
						end else if (is_task) begin
							busy_reg <= 1'b1;
							wide_reg <= wide;
							cnt_reg <= SWITCH_CYC;
							state_reg <= ST_TASK;
						end else begin
							busy_reg <= 1'b1;
							wide_reg <= wide;
							// Stack selector, pointer, parameters, return address
							npush_reg <= 5'h00;
							cnt_reg <= {11'h000, desc_q[12:8]} + 16'h0003;
							if (desc_q[1]) begin
								cnt_reg <= 16'h0003;
								if (desc_q[2:0] == 3'b110) begin
									flags_reg[`GTS_FL_IF] <= 1'b0;
									if (cmd_op == `GTS_OP_INT) begin
										saved_flags_reg <= flags_reg;
										saved_nt_valid_reg <= 1'b1;
									end
								end
								if (cmd_op == `GTS_OP_INT)
									flags_reg[`GTS_FL_NT] <= 1'b0;
							end
							state_reg <= ST_PUSH;
						end
					end
				end
				ST_PUSH: begin
					npush_reg <= npush_reg + 5'h01;
					if (npush_reg == 5'h00)
						last_push_reg <= wide_reg ? {16'h0000, sel_q[15:0]} :
							{16'h0000, sel_q[15:0]};
					else
						last_push_reg <= wide_reg ? base_q : {16'h0000, base_q[15:0]};
					cnt_reg <= cnt_reg - 16'h0001;
					if (cnt_reg == 16'h0001)
						state_reg <= ST_DONE;
				end
				ST_TASK: begin
					cnt_reg <= cnt_reg - 16'h0001;
					if (cnt_reg == 16'h0001)
						state_reg <= ST_DONE;
				end
				ST_DONE: begin
					busy_reg <= 1'b0;
					done_reg <= 1'b1;
					if (is_task || op_reg == `GTS_OP_INTERRUPT_RETURN) begin
						// Nested return goes back through the stored link
						task_segment_selector_reg <= (op_reg == `GTS_OP_INTERRUPT_RETURN) ? back_link_reg :
							sel_q[15:0];
						tr_base_reg <= base_q;
						tr_limit_reg <= limit_q;
						flags_reg[`GTS_FL_VM] <= desc_q[14];
						if (op_reg == `GTS_OP_INTERRUPT_RETURN)
							flags_reg[`GTS_FL_NT] <= 1'b0;
						if (op_reg == `GTS_OP_CALL || op_reg == `GTS_OP_INT) begin
							back_link_reg <= task_segment_selector_reg;
							flags_reg[`GTS_FL_NT] <= 1'b1;
						end
						if (is_tss || op_reg != `GTS_OP_INTERRUPT_RETURN)
							busy_type_reg <= wide_reg ? `GTS_DT_TSS32_BUSY :
								`GTS_DT_TSS16_BUSY;
						if (desc_q[13])
							exc_reg <= `GTS_EXC_DEBUG;
					end
					state_reg <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Task-switched bit set by hardware, also writable through control word bit 3
	always @(posedge aclk) begin
		if (!aresetn)
			dbg_pending_reg <= 1'b0;
		else
			dbg_pending_reg <= (state_reg == ST_DONE) &&
				(is_task || op_reg == `GTS_OP_INTERRUPT_RETURN);
	end
	always @(posedge aclk) begin
		if (!aresetn)
			ts_reg <= 1'b0;
		else if (dbg_pending_reg)
			ts_reg <= 1'b1;
		else if (wr_ctrl && w_strb_reg[0])
			ts_reg <= w_data_reg[`GTS_CR0_TS];
	end
endmodule // gts_task_ctrl

// ---- sim/gts_task_ctrl_assertions.sv ----
// Protocol and timing checks for the gate and task switch controller
`timescale 1ns/10ps
`include "gts_defines.vh"
module gts_task_ctrl_assertions (
	input logic        aclk,
	input logic        aresetn,
	input logic        s_axi_wvalid,
	input logic        s_axi_wready,
	input logic [1:0]  s_axi_bresp,
	input logic        s_axi_bvalid,
	input logic        s_axi_bready,
	input logic        s_axi_arvalid,
	input logic        s_axi_arready,
	input logic [31:0] s_axi_rdata,
	input logic [1:0]  s_axi_rresp,
	input logic        s_axi_rvalid,
	input logic        s_axi_rready,
	input logic        busy_reg
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	AST_RST_IDLE: assert property (!$past(aresetn) |-> !busy_reg && !s_axi_bvalid && !s_axi_rvalid)
		else $error("outputs active right after reset");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response changed before taken");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
		&& $stable(s_axi_rresp))
		else $error("read response changed before taken");
	AST_B_ANSWER: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
		else $error("no write response in time");
	AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("no read response in time");
	AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	AST_R_DROP: assert property (s_axi_rvalid && s_axi_rready && !s_axi_arvalid |=> !s_axi_rvalid)
		else $error("read response repeated");
	AST_BUSY_BOUND: assert property ($rose(busy_reg) |-> ##[1:120] !busy_reg)
		else $error("transfer ran too long");

	cover property ($fell(busy_reg));
	cover property (s_axi_rvalid && s_axi_rresp == `GTS_RESP_SLVERR);
	cover property (s_axi_bvalid && s_axi_bready);
endmodule // gts_task_ctrl_assertions

bind gts_task_ctrl gts_task_ctrl_assertions i_chk (.aclk(aclk), .aresetn(aresetn),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .busy_reg(busy_reg));

// ---- sim/gts_task_ctrl_tb.sv ----
// Self-checking testbench for the gate and task switch controller
`timescale 1ns/10ps
`include "gts_defines.vh"
module gts_task_ctrl_tb;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire         busy_reg;
	wire [1:0]   s_axi_bresp, s_axi_rresp;
	wire [31:0]  s_axi_rdata;
	int          num_errors = 0;
	int          checks_done = 0;
	int          cyc;
	logic [31:0] rd_q;
	logic [1:0]  resp_q;

	gts_task_ctrl i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .busy_reg(busy_reg));

	initial begin
		forever #50 aclk = ~aclk;
	end

	task conclude;
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %0t %s: saw %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task tmo(input int n);
		if (n >= 200) begin
			num_errors++;
			$display("BAD %0t wait timed out", $time);
			conclude;
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		int   n;
		logic ta, tw, da, dw;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		da = 1'b0;
		dw = 1'b0;
		for (n = 0; n < 200 && !(da && dw); n++) begin
			@(negedge aclk);
			ta = s_axi_awready & ~da;
			tw = s_axi_wready & ~dw;
			@(posedge aclk);
			if (ta)
				s_axi_awvalid <= 1'b0;
			if (tw)
				s_axi_wvalid <= 1'b0;
			da = da | ta;
			dw = dw | tw;
		end
		tmo(n);
		for (n = 0; n < 200; n++) begin
			@(negedge aclk);
			if (s_axi_bvalid === 1'b1)
				break;
		end
		tmo(n);
		resp_q = s_axi_bresp;
		@(posedge aclk);
		s_axi_bready <= 1'b0;
	endtask

	task rd(input logic [7:0] a);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(negedge aclk);
			if (s_axi_arready === 1'b1)
				break;
		end
		tmo(n);
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		for (n = 0; n < 200; n++) begin
			@(negedge aclk);
			if (s_axi_rvalid === 1'b1)
				break;
		end
		tmo(n);
		rd_q = s_axi_rdata;
		resp_q = s_axi_rresp;
		@(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask

	task rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
		rd(a);
		chk(rd_q & m, e, s);
	endtask

	// Issue a command and count the cycles it stays busy
	task cmd(input logic [2:0] op);
		wr(`GTS_ADDR_CMD, {29'h0, op});
		for (cyc = 0; cyc < 200; cyc++) begin
			@(negedge aclk);
			if (busy_reg !== 1'b1)
				break;
		end
		tmo(cyc);
	endtask

	task xfer(input [15:0] sel, input [31:0] desc, input [31:0] lim, input [1:0] cpl, input [2:0] op);
		wr(`GTS_ADDR_LIMIT, lim);
		wr(`GTS_ADDR_DESC, desc);
		wr(`GTS_ADDR_SEL, {cpl, 14'h0, sel});
		cmd(op);
	endtask

	task t_reset;
		chk(busy_reg, 32'h0, "busy at reset");
		rdchk(`GTS_ADDR_CTRL, 32'h1, 32'h0, "real mode");
		rd(8'h40);
		chk(resp_q, `GTS_RESP_SLVERR, "unmapped resp");
		chk(rd_q, 32'h0, "unmapped data");
		xfer(16'h0020, 32'h39, 32'h65, 2'h0, `GTS_OP_CALL);
		rdchk(`GTS_ADDR_TRSEL, 32'hFFFF, 32'h0, "no switch in real mode");
		wr(`GTS_ADDR_CTRL, 32'h1);
		rdchk(`GTS_ADDR_CTRL, 32'h1, 32'h1, "protected mode");
		$display("test reset done");
	endtask

	task t_switch;
		xfer(16'h0028, 32'h39, 32'h65, 2'h0, `GTS_OP_CALL);
		chk(cyc >= 90 && cyc <= 110, 32'h1, "switch length");
		rdchk(`GTS_ADDR_STATUS, 32'hFFFFFFF0, 32'hB0000000, "busy 32");
		rdchk(`GTS_ADDR_CTRL, 32'h8, 32'h8, "task switched");
		rdchk(`GTS_ADDR_TRSEL, 32'hFFFF, 32'h28, "selector");
		rdchk(`GTS_ADDR_TRLIM, 32'hFFFFFFFF, 32'h65, "hidden limit");
		rdchk(`GTS_ADDR_FLAGS, 32'h4000, 32'h4000, "nested set");
		xfer(16'h0030, 32'h31, 32'h2C, 2'h0, `GTS_OP_CALL);
		rdchk(`GTS_ADDR_STATUS, 32'hFFFFFFF0, 32'h30028000, "busy 16 link");
		$display("test switch done");
	endtask

	task t_fault;
		logic [31:0] d [5] = '{32'h3B, 32'h39, 32'h31, 32'h0E, 32'h2039};
		logic [31:0] l [5] = '{32'h65, 32'h64, 32'h2B, 32'h65, 32'h65};
		logic [1:0]  c [5] = '{2'h0, 2'h0, 2'h0, 2'h3, 2'h0};
		logic [2:0]  o [5] = '{`GTS_OP_CALL, `GTS_OP_JMP, `GTS_OP_CALL, `GTS_OP_INT, `GTS_OP_CALL};
		logic [7:0]  e [5] = '{`GTS_EXC_GP, `GTS_EXC_GP, `GTS_EXC_GP, `GTS_EXC_GP, `GTS_EXC_DEBUG};
		for (int i = 0; i < 5; i++) begin
			xfer(16'h0038, d[i], l[i], c[i], o[i]);
			rdchk(`GTS_ADDR_STATUS, 32'hFF0, {20'h0, e[i], 4'h0}, "exception");
			rdchk(`GTS_ADDR_TRSEL, 32'hFFFF, (i < 4) ? 32'h30 : 32'h38, "task after");
		end
		$display("test fault done");
	endtask

	task t_gate;
		wr(`GTS_ADDR_FLAGS, 32'h4200);
		xfer(16'h0008, 32'h3E, 32'h0, 2'h3, `GTS_OP_INT);
		rdchk(`GTS_ADDR_FLAGS, 32'h4200, 32'h0, "interrupt gate");
		wr(`GTS_ADDR_FLAGS, 32'h200);
		xfer(16'h0008, 32'h3F, 32'h0, 2'h3, `GTS_OP_INT);
		rdchk(`GTS_ADDR_FLAGS, 32'h200, 32'h200, "trap gate");
		xfer(16'h0010, 32'hFC, 32'h0, 2'h0, `GTS_OP_CALL);
		rdchk(`GTS_ADDR_STATUS, 32'hFF0, 32'hD0, "outward gate");
		$display("test gate done");
	endtask

	task t_fpu_ret;
		wr(`GTS_ADDR_CTRL, 32'hB);
		cmd(`GTS_OP_FPU);
		rdchk(`GTS_ADDR_STATUS, 32'hFF0, 32'h70, "numeric unit");
		wr(`GTS_ADDR_FLAGS, 32'h0);
		cmd(`GTS_OP_INTERRUPT_RETURN);
		rdchk(`GTS_ADDR_TRSEL, 32'hFFFF, 32'h38, "plain return");
		wr(`GTS_ADDR_FLAGS, 32'h4000);
		cmd(`GTS_OP_INTERRUPT_RETURN);
		rdchk(`GTS_ADDR_TRSEL, 32'hFFFF, 32'h30, "nested return");
		$display("test fpu and return done");
	endtask

	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_switch;
		t_fault;
		t_gate;
		t_fpu_ret;
		conclude;
	end
endmodule // gts_task_ctrl_tb
